// ### rfa_bank.sv
// Purpose: demonstration register bank with one word of each field access kind
// Assumes: strobe port on i_clk; event inputs come from logic on i_clk; status levels are pins
// Notes:   read data appears one cycle after the read strobe with o_rvalid

`timescale 1ns/1ps
`default_nettype none

// Contract
// - readable fields return contents on read; writable fields take written data.
// - read-only fields return their value and ignore all writes.
// - clear-on-read fields return value, then clear to zero; writes ignored.
// - write-only fields accept writes; read value is unspecified, here zero.
// - write-one-clear fields clear bits written one, keep bits written zero.
// - sticky-low status holds low until read, then follows its condition.
// - sticky-high status holds high until read, then follows its condition.
// - self-clearing fields drop to zero alone; zero writes do nothing; readable.
module rfa_bank (
   // clock and reset
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   // register strobe port
   input  wire logic                      i_wr,
   input  wire logic                      i_rd,
   input  wire logic [rfa_pkg::AW-1:0]    i_addr,
   input  wire logic [rfa_pkg::DW-1:0]    i_wdata,
   output logic      [rfa_pkg::DW-1:0]    o_rdata,
   output logic                           o_rvalid,
   // hardware status and events
   input  wire logic [rfa_pkg::DW-1:0]    i_status,
   input  wire logic [rfa_pkg::DW-1:0]    i_cond_low,
   input  wire logic [rfa_pkg::DW-1:0]    i_cond_high,
   input  wire logic [rfa_pkg::DW-1:0]    i_event_cor,
   input  wire logic [rfa_pkg::DW-1:0]    i_event_w1c,
   // field outputs toward the core
   output logic      [rfa_pkg::DW-1:0]    o_ctrl,
   output logic      [rfa_pkg::DW-1:0]    o_write_only_field,
   output logic      [rfa_pkg::DW-1:0]    o_self_clearing_field
);
   localparam int unsigned N = rfa_pkg::NREG;

   logic [rfa_pkg::DW-1:0] sync1_q [3];
   logic [rfa_pkg::DW-1:0] sync2_q [3];
   logic [rfa_pkg::DW-1:0] sync1_d [3];
   logic [rfa_pkg::DW-1:0] sync2_d [3];
   logic [rfa_pkg::DW-1:0] hw      [N];
   logic [rfa_pkg::DW-1:0] val     [N];
   logic [rfa_pkg::DW-1:0] rdv     [N];
   logic [N-1:0]           wr_sel;
   logic [N-1:0]           rd_sel;
   logic [rfa_pkg::DW-1:0] rdata_d;
   logic [rfa_pkg::DW-1:0] rdata_q;
   logic                   rvalid_d;
   logic                   rvalid_q;

   // two-stage synchronisers for the pin-level status inputs
   always_comb begin
      sync1_d[0] = i_status;
      sync1_d[1] = i_cond_low;
      sync1_d[2] = i_cond_high;
      sync2_d    = sync1_q;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sync1_q[0] <= rfa_pkg::RST_ZERO;
         sync1_q[1] <= rfa_pkg::RST_ONES;
         sync1_q[2] <= rfa_pkg::RST_ZERO;
         sync2_q[0] <= rfa_pkg::RST_ZERO;
         sync2_q[1] <= rfa_pkg::RST_ONES;
         sync2_q[2] <= rfa_pkg::RST_ZERO;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   // hardware input of each word
   always_comb begin
      for (int i = 0; i < N; i++) begin
         hw[i] = rfa_pkg::RST_ZERO;
      end
      hw[rfa_pkg::IX_STAT] = sync2_q[0];
      hw[rfa_pkg::IX_SLO]  = sync2_q[1];
      hw[rfa_pkg::IX_SHI]  = sync2_q[2];
      hw[rfa_pkg::IX_COR]  = i_event_cor;
      hw[rfa_pkg::IX_W1C]  = i_event_w1c;
   end

   // one field word per register; strobes reach only the addressed word
   for (genvar g = 0; g < N; g++) begin : g_reg
      assign wr_sel[g] = i_wr && (i_addr == rfa_pkg::off_of(g));
      assign rd_sel[g] = i_rd && (i_addr == rfa_pkg::off_of(g));

      rfa_field #(
         .KIND (rfa_pkg::kind_of(g)),
         .RST  (rfa_pkg::rst_of(g))
      ) u_field (
         .i_clk   (i_clk),
         .i_rst_n (i_rst_n),
         .i_wr    (wr_sel[g]),
         .i_rd    (rd_sel[g]),
         .i_wdata (i_wdata),
         .i_hw    (hw[g]),
         .o_value (val[g]),
         .o_rdval (rdv[g])
      );
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rdata_d  = rfa_pkg::RST_ZERO;
      rvalid_d = i_rd;
      for (int i = 0; i < N; i++) begin
         if (rd_sel[i]) begin
            rdata_d = rdv[i];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rdata_q  <= rfa_pkg::RST_ZERO;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign o_rdata               = rdata_q;
   assign o_rvalid              = rvalid_q;
   assign o_ctrl                = val[rfa_pkg::IX_CTRL];
   assign o_write_only_field    = val[rfa_pkg::IX_WOF];
   assign o_self_clearing_field = val[rfa_pkg::IX_SCF];

   // checks
   sequence s_scf_set;
      wr_sel[rfa_pkg::IX_SCF] && (i_wdata != rfa_pkg::RST_ZERO);
   endsequence

   sequence s_scf_idle;
      !wr_sel[rfa_pkg::IX_SCF];
   endsequence

   sequence s_cor_read;
      rd_sel[rfa_pkg::IX_COR] && (i_event_cor == rfa_pkg::RST_ZERO);
   endsequence

   property p_rw_write;
      @(posedge i_clk) disable iff (!i_rst_n)
      wr_sel[rfa_pkg::IX_CTRL] |=> (o_ctrl == $past(i_wdata));
   endproperty
   a_rw_write: assert property (p_rw_write) else $error("control word missed a write");

   property p_rw_read;
      @(posedge i_clk) disable iff (!i_rst_n)
      (rd_sel[rfa_pkg::IX_CTRL] && !i_wr) |=> (o_rvalid && o_rdata == $past(o_ctrl));
   endproperty
   a_rw_read: assert property (p_rw_read) else $error("control word read wrong data");

   property p_ro_ignores_write;
      @(posedge i_clk) disable iff (!i_rst_n)
      1'b1 |=> (val[rfa_pkg::IX_STAT] == $past(sync2_q[0]));
   endproperty
   a_ro_ignores_write: assert property (p_ro_ignores_write) else $error("status word moved off its input");

   property p_cor_clears;
      @(posedge i_clk) disable iff (!i_rst_n)
      s_cor_read |=> (val[rfa_pkg::IX_COR] == rfa_pkg::RST_ZERO) && (o_rdata == $past(val[rfa_pkg::IX_COR]));
   endproperty
   a_cor_clears: assert property (p_cor_clears) else $error("clear-on-read word not cleared");

   property p_wof_reads_zero;
      @(posedge i_clk) disable iff (!i_rst_n)
      rd_sel[rfa_pkg::IX_WOF] |=> (o_rdata == rfa_pkg::RST_ZERO);
   endproperty
   a_wof_reads_zero: assert property (p_wof_reads_zero) else $error("write-only word leaked on read");

   property p_w1c;
      @(posedge i_clk) disable iff (!i_rst_n)
      (wr_sel[rfa_pkg::IX_W1C] && i_event_w1c == rfa_pkg::RST_ZERO)
         |=> (val[rfa_pkg::IX_W1C] == ($past(val[rfa_pkg::IX_W1C]) & ~$past(i_wdata)));
   endproperty
   a_w1c: assert property (p_w1c) else $error("write-one-clear word wrong after write");

   property p_slo_holds;
      @(posedge i_clk) disable iff (!i_rst_n)
      !rd_sel[rfa_pkg::IX_SLO] |=> ((val[rfa_pkg::IX_SLO] & ~$past(val[rfa_pkg::IX_SLO])) == rfa_pkg::RST_ZERO);
   endproperty
   a_slo_holds: assert property (p_slo_holds) else $error("sticky-low bit rose without a read");

   // a read releases the latch: the word takes the synchronised condition
   property p_slo_release;
      @(posedge i_clk) disable iff (!i_rst_n)
      rd_sel[rfa_pkg::IX_SLO] |=> (val[rfa_pkg::IX_SLO] == $past(sync2_q[1]));
   endproperty
   a_slo_release: assert property (p_slo_release) else $error("sticky-low bit not released by read");

   property p_shi_holds;
      @(posedge i_clk) disable iff (!i_rst_n)
      !rd_sel[rfa_pkg::IX_SHI] |=> ((~val[rfa_pkg::IX_SHI] & $past(val[rfa_pkg::IX_SHI])) == rfa_pkg::RST_ZERO);
   endproperty
   a_shi_holds: assert property (p_shi_holds) else $error("sticky-high bit fell without a read");

   property p_shi_release;
      @(posedge i_clk) disable iff (!i_rst_n)
      rd_sel[rfa_pkg::IX_SHI] |=> (val[rfa_pkg::IX_SHI] == $past(sync2_q[2]));
   endproperty
   a_shi_release: assert property (p_shi_release) else $error("sticky-high bit not released by read");

   property p_scf_clears;
      @(posedge i_clk) disable iff (!i_rst_n)
      s_scf_set ##1 s_scf_idle |=> (o_self_clearing_field == rfa_pkg::RST_ZERO);
   endproperty
   a_scf_clears: assert property (p_scf_clears) else $error("self-clearing word did not clear");

   property p_cor_other_read;
      @(posedge i_clk) disable iff (!i_rst_n)
      (!rd_sel[rfa_pkg::IX_COR] && i_event_cor == rfa_pkg::RST_ZERO)
         |=> (val[rfa_pkg::IX_COR] == $past(val[rfa_pkg::IX_COR]));
   endproperty
   a_cor_other_read: assert property (p_cor_other_read) else $error("clear-on-read word changed unread");
endmodule : rfa_bank

`default_nettype wire

// ### rfa_field.sv
// Purpose: register field access library: shared constants and one field primitive
// Assumes: single clock i_clk, synchronous active-low reset, strobes already decoded per register
// Notes:   one instance holds one register word; the access kind is a parameter

package rfa_pkg;
   // bus geometry
   localparam int unsigned DW   = 16;
   localparam int unsigned AW   = 4;
   localparam int unsigned NREG = 8;

   // access kinds that a field may carry
   typedef enum {
      rfa_rw, rfa_ro, rfa_clear_on_read, rfa_write_only_field,
      rfa_write_one_clear, rfa_sticky_low_status, rfa_sticky_high_status,
      rfa_self_clearing_field
   } rfa_kind_t;

   // register offsets (word addresses on the strobe port)
   localparam logic [AW-1:0] OFF_CTRL = 4'h0;
   localparam logic [AW-1:0] OFF_STAT = 4'h1;
   localparam logic [AW-1:0] OFF_COR  = 4'h2;
   localparam logic [AW-1:0] OFF_WOF  = 4'h3;
   localparam logic [AW-1:0] OFF_W1C  = 4'h4;
   localparam logic [AW-1:0] OFF_SLO  = 4'h5;
   localparam logic [AW-1:0] OFF_SHI  = 4'h6;
   localparam logic [AW-1:0] OFF_SCF  = 4'h7;

   // register index of each kind in the bank
   localparam int unsigned IX_CTRL = 0;
   localparam int unsigned IX_STAT = 1;
   localparam int unsigned IX_COR  = 2;
   localparam int unsigned IX_WOF  = 3;
   localparam int unsigned IX_W1C  = 4;
   localparam int unsigned IX_SLO  = 5;
   localparam int unsigned IX_SHI  = 6;
   localparam int unsigned IX_SCF  = 7;

   // reset values
   localparam logic [DW-1:0] RST_ZERO = 16'h0000;
   localparam logic [DW-1:0] RST_ONES = 16'hffff;
   localparam logic [DW-1:0] RST_CTRL = 16'h0000;

   // offset of register index i
   function automatic logic [AW-1:0] off_of(input int unsigned i);
      case (i)
         IX_CTRL: off_of = OFF_CTRL;
         IX_STAT: off_of = OFF_STAT;
         IX_COR:  off_of = OFF_COR;
         IX_WOF:  off_of = OFF_WOF;
         IX_W1C:  off_of = OFF_W1C;
         IX_SLO:  off_of = OFF_SLO;
         IX_SHI:  off_of = OFF_SHI;
         default: off_of = OFF_SCF;
      endcase
   endfunction : off_of

   // access kind of register index i
   function automatic rfa_kind_t kind_of(input int unsigned i);
      case (i)
         IX_CTRL: kind_of = rfa_rw;
         IX_STAT: kind_of = rfa_ro;
         IX_COR:  kind_of = rfa_clear_on_read;
         IX_WOF:  kind_of = rfa_write_only_field;
         IX_W1C:  kind_of = rfa_write_one_clear;
         IX_SLO:  kind_of = rfa_sticky_low_status;
         IX_SHI:  kind_of = rfa_sticky_high_status;
         default: kind_of = rfa_self_clearing_field;
      endcase
   endfunction : kind_of

   // reset value of register index i; a sticky-low word starts high so no false latch shows
   function automatic logic [DW-1:0] rst_of(input int unsigned i);
      case (i)
         IX_CTRL: rst_of = RST_CTRL;
         IX_SLO:  rst_of = RST_ONES;
         default: rst_of = RST_ZERO;
      endcase
   endfunction : rst_of
endpackage : rfa_pkg

`timescale 1ns/1ps
`default_nettype none

module rfa_field #(
   parameter rfa_pkg::rfa_kind_t          KIND = rfa_pkg::rfa_rw,
   parameter logic [rfa_pkg::DW-1:0]      RST  = rfa_pkg::RST_ZERO
) (
   // clock and reset
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   // decoded access strobes for this word
   input  wire logic                      i_wr,
   input  wire logic                      i_rd,
   input  wire logic [rfa_pkg::DW-1:0]    i_wdata,
   // hardware side: status level or event pulses
   input  wire logic [rfa_pkg::DW-1:0]    i_hw,
   // field contents and the value a read returns
   output logic      [rfa_pkg::DW-1:0]    o_value,
   output logic      [rfa_pkg::DW-1:0]    o_rdval
);
   logic [rfa_pkg::DW-1:0] val_q;
   logic [rfa_pkg::DW-1:0] val_d;

   // next value per access kind; hardware sets win over a clear in the same cycle
   always_comb begin
      case (KIND)
         rfa_pkg::rfa_rw:                  val_d = i_wr ? i_wdata : val_q;
         rfa_pkg::rfa_ro:                  val_d = i_hw;
         rfa_pkg::rfa_clear_on_read:       val_d = i_hw | (i_rd ? '0 : val_q);
         rfa_pkg::rfa_write_only_field:    val_d = i_wr ? i_wdata : val_q;
         rfa_pkg::rfa_write_one_clear:     val_d = i_hw | (val_q & ~(i_wr ? i_wdata : '0));
         rfa_pkg::rfa_sticky_low_status:   val_d = i_rd ? i_hw : (val_q & i_hw);
         rfa_pkg::rfa_sticky_high_status:  val_d = i_rd ? i_hw : (val_q | i_hw);
         rfa_pkg::rfa_self_clearing_field: val_d = i_wr ? i_wdata : '0;
         default:                          val_d = val_q;
      endcase
   end

   // field storage
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         val_q <= RST;
      end else begin
         val_q <= val_d;
      end
   end

   // write-only words read back as zero; everything else shows its contents
   assign o_rdval = (KIND == rfa_pkg::rfa_write_only_field) ? '0 : val_q;
   assign o_value = val_q;
endmodule : rfa_field

`default_nettype wire

// ### rfa_bank_tb.sv
// Purpose: self-checking bench for the register field bank
// Assumes: inputs change by non-blocking assignment at the rising edge
// Notes:   a cycle model of every word is compared with the outputs on each falling edge
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam int NCYC = 3000;

   // design inputs
   logic        i_clk       = 1'b0;
   logic        i_rst_n     = 1'b0;
   logic        i_wr        = 1'b0;
   logic        i_rd        = 1'b0;
   logic [3:0]  i_addr      = 4'h0;
   logic [15:0] i_wdata     = 16'h0000;
   logic [15:0] i_status    = 16'h0000;
   logic [15:0] i_cond_low  = 16'hffff;
   logic [15:0] i_cond_high = 16'h0000;
   logic [15:0] i_event_cor = 16'h0000;
   logic [15:0] i_event_w1c = 16'h0000;
   // design outputs
   logic [15:0] o_rdata;
   logic        o_rvalid;
   logic [15:0] o_ctrl;
   logic [15:0] o_write_only_field;
   logic [15:0] o_self_clearing_field;
   // model state: words, two synchroniser stages, pending reads
   int          m [8];
   int          s1 [3];
   int          s2 [3];
   int          rq [$];
   int          a;
   int          w;
   int          e;
   int          v;
   int          r;
   bit          rd;
   bit          wr;
   bit          quiet;
   int          n_mismatch = 0;
   int          n_compared = 0;

   rfa_bank dut (
      .i_clk                 (i_clk),
      .i_rst_n               (i_rst_n),
      .i_wr                  (i_wr),
      .i_rd                  (i_rd),
      .i_addr                (i_addr),
      .i_wdata               (i_wdata),
      .o_rdata               (o_rdata),
      .o_rvalid              (o_rvalid),
      .i_status              (i_status),
      .i_cond_low            (i_cond_low),
      .i_cond_high           (i_cond_high),
      .i_event_cor           (i_event_cor),
      .i_event_w1c           (i_event_w1c),
      .o_ctrl                (o_ctrl),
      .o_write_only_field    (o_write_only_field),
      .o_self_clearing_field (o_self_clearing_field)
   );

   // 250 MHz clock
   always #2 i_clk = ~i_clk;

   // compare one value, count it, report a difference
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // print counts and verdict, then stop
   task automatic final_report();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report

   // cycle model: inputs sampled at the edge, before the bench's own updates land
   always @(posedge i_clk) begin
      a  = i_addr;
      w  = i_wdata;
      rd = i_rd;
      wr = i_wr;
      if (!i_rst_n) begin
         foreach (m[k]) m[k] = 0;
         m[5] = 16'hffff;
         s1   = '{0, 16'hffff, 0};
         s2   = '{0, 16'hffff, 0};
         rq.delete();
      end else begin
         // a read returns the value before its own side effect
         if (rd) rq.push_back((a << 16) | ((a < 8) ? m[a] : 0));
         m[0] = (wr && a == 0) ? w : m[0];
         m[1] = s2[0];
         m[2] = i_event_cor | ((rd && a == 2) ? 0 : m[2]);
         m[3] = (wr && a == 3) ? w : m[3];
         m[4] = i_event_w1c | (m[4] & ~((wr && a == 4) ? w : 0));
         m[5] = (rd && a == 5) ? s2[1] : (m[5] & s2[1]);
         m[6] = (rd && a == 6) ? s2[2] : (m[6] | s2[2]);
         m[7] = (wr && a == 7) ? w : 0;
         s2   = s1;
         s1   = '{i_status, i_cond_low, i_cond_high};
      end
   end

   // compare every result but write-only read data in mid-cycle, when the outputs are settled
   always @(negedge i_clk) begin
      e = (rq.size() != 0) ? rq.pop_front() : -1;
      v = e & 16'hffff;
      check("rvalid", {15'h0000, o_rvalid}, {15'h0000, e >= 0});
      if (e >= 0) begin
         case (e >> 16)
            0: check("rd_ctrl", o_rdata, v);
            1: check("rd_status", o_rdata, v);
            2: check("rd_clear_on_read", o_rdata, v);
            3: ; // write-only read data is not relied on
            4: check("rd_write_one_clear", o_rdata, v);
            5: check("rd_sticky_low", o_rdata, v);
            6: check("rd_sticky_high", o_rdata, v);
            7: check("rd_self_clearing", o_rdata, v);
            default: check("rd_unmapped", o_rdata, v);
         endcase
      end
      check("ctrl", o_ctrl, m[0]);
      check("write_only", o_write_only_field, m[3]);
      check("self_clearing", o_self_clearing_field, m[7]);
   end

   // random traffic on every port, with a second reset in mid-run
   initial begin
      r = $urandom(66);
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (int c = 0; c < NCYC; c++) begin
         @(posedge i_clk);
         if (c == NCYC / 2) i_rst_n <= 1'b0;
         if (c == NCYC / 2 + 3) i_rst_n <= 1'b1;
         quiet       = (c >= NCYC / 2) && (c < NCYC / 2 + 3); // no access while reset is held
         i_rd        <= !quiet && (($urandom % 3) == 0);
         i_wr        <= !quiet && (($urandom % 3) == 0);
         i_addr      <= 4'($urandom % 10);
         i_wdata     <= 16'($urandom); // all bits live, none reserved
         i_event_cor <= (($urandom % 4) == 0) ? 16'(1 << ($urandom % 16)) : 16'h0000;
         i_event_w1c <= (($urandom % 4) == 0) ? 16'(1 << ($urandom % 16)) : 16'h0000;
         if (($urandom % 8) == 0) i_status <= 16'($urandom);
         if (($urandom % 6) == 0) i_cond_low <= 16'($urandom | $urandom);
         if (($urandom % 6) == 0) i_cond_high <= 16'($urandom & $urandom & $urandom);
      end
      @(posedge i_clk);
      i_rd <= 1'b0;
      i_wr <= 1'b0;
      repeat (3) @(posedge i_clk);
      final_report();
   end

   // watchdog well beyond the planned run
   initial begin
      #((NCYC + 1000) * 4);
      n_mismatch++;
      final_report();
   end
endmodule : testbench

`default_nettype wire
